// ===== src/lcd_palette_defs.svh
// Register map, field positions, reset values and timing counts for the palette and display-halt block
`ifndef LCD_PALETTE_DEFS_SVH
`define LCD_PALETTE_DEFS_SVH

// ==================================================
// Register indices (byte address = 4 x index)
`define PAL_ENTRY_IDX_BASE 12'h800
`define PAL_ENTRY_IDX_LAST 12'hBFC
`define START_ADDR_IDX 12'hC08
`define LINE_OFFSET_IDX 12'hC10
`define PAL_CTRL_IDX 12'hC12
`define HORIZ_CHARS_IDX 12'hC14
`define VERT_LINES_IDX 12'hC18
`define POWER_MGMT_IDX 12'hC24
`define DISPLAY_CTRL_IDX 12'hC28

// ==================================================
// Reset values
`define START_ADDR_RST 32'h0C000000
`define LINE_OFFSET_RST 16'h0280
`define HORIZ_CHARS_RST 16'h4F52
`define VERT_LINES_RST 16'h01DF
`define POWER_MGMT_RST 16'h0010
`define DISPLAY_CTRL_RST 16'h0000

// ==================================================
// Field positions
`define PAL_WRITE_EN_BIT 0
`define PAL_STATE_BIT 8
`define DISPLAY_ON_BIT 0
`define INDEXED_MODE_BIT 8
`define MONO_MODE_BIT 9
`define HORIZ_DISPLAY_CHARS_MSB 15
`define HORIZ_DISPLAY_CHARS_LSB 8
`define VERT_DISPLAY_LINES_MSB 10

// ==================================================
// Sizes and timing
`define PAL_DEPTH 256
`define LINE_BUF_DEPTH 1228
`define MAX_BURST 6'h20
`define PAL_ENTER_CYC 2'h2
`define PWR_STEP_NS 1000
`define CLK_PERIOD_NS 100
`define PWR_STEP_CYC ((`PWR_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/lcd_palette_pkg.sv
// Types shared by the palette and display-halt block
package lcd_palette_pkg;
  typedef enum logic [1:0] {FETCH_IDLE, FETCH_REQ, FETCH_DATA, LINE_SHOW} fetch_state_t;
  typedef logic [1:0] power_state_t;
endpackage : lcd_palette_pkg

// ===== src/ram_if.sv
// Port bundle between the controller and one of its memories
`timescale 1ns/1ps
`default_nettype none
interface ram_if #(parameter int AW = 8, parameter int DW = 24);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport ram (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ram_if
`default_nettype wire

// ===== src/ram_block.sv
// Simple two-port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ram_block #(
  parameter int AW = 8,
  parameter int DW = 24,
  parameter int DEPTH = 256
) (
  input wire logic clk,
  ram_if.ram port
);
  logic [DW-1:0] mem [DEPTH];

  // Write port; addresses beyond the depth are dropped
  always_ff @(posedge clk) begin
    if (port.we && (int'(port.waddr) < DEPTH)) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  // Read data leaves from a register, one cycle after the address
  always_ff @(posedge clk) begin
    port.rdata <= mem[port.raddr];
  end
endmodule : ram_block
`default_nettype wire

// ===== src/lcd_palette_ctrl.sv
// Palette lookup, palette update handshake, frame fetch and display-off sequencing
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_palette_defs.svh"

// Operation
// - A 256-entry lookup table holds 24-bit colours.
// - From reset, with write enable clear, pixels use the table normally.
// - Setting write enable enters update mode three clocks later.
// - Update mode reads back as state flag 1; software polls it.
// - Clearing write enable returns to normal mode one clock later.
// - While the state flag is 1, pixel output is all zero.
// - Entry bits 31..24 are read-only zero; writes ignored.
// - Colour entry is R 23:16, G 15:8, B 7:0; mono uses 7:0.
// - Clearing display-on starts the display power-down.
// - After display-off, both power state bits fall to 0.
// - Pixel data is fetched ahead of display from shared memory.
// - Reads are bursts of at most 32; a 2.4 KB line buffer holds them.
// - Geometry up to 1024 x 1024 at 16 bits per pixel.
// - Char count and line count registers hold value minus one.
// - In colour mode only 5:6:5 bits of each entry reach the pixel output; mono uses bits 7:2.
module lcd_palette_ctrl
  import lcd_palette_pkg::*;
#(
  parameter int PWR_STEP_CYCLES = `PWR_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic panel_dot_clock,
  output logic [15:0] panel_pixel_out,
  output logic display_on_out,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [5:0] mem_burst_len,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [15:0] mem_rdata
);

  // ==================================================
  // Memories
  ram_if #(.AW(8), .DW(24)) pal_port ();
  ram_if #(.AW(11), .DW(16)) lb_port ();

  ram_block #(.AW(8), .DW(24), .DEPTH(`PAL_DEPTH)) u_palette (
    .clk(pclk),
    .port(pal_port.ram)
  );

  ram_block #(.AW(11), .DW(16), .DEPTH(`LINE_BUF_DEPTH)) u_line_buf (
    .clk(pclk),
    .port(lb_port.ram)
  );

  // ==================================================
  // Registers and state
  logic [31:0] start_addr_q;
  logic [15:0] line_offset_q;
  logic [15:0] horiz_chars_q;
  logic [15:0] vert_lines_q;
  logic [15:0] power_mgmt_q;
  logic [15:0] display_ctrl_q;
  logic palette_write_enable_q;
  logic palette_state_flag_q;
  logic [1:0] pal_cnt_q;
  power_state_t power_state_q;
  logic [15:0] pwr_cnt_q;
  logic acc_q;
  logic [31:0] prdata_q;
  logic [11:0] idx;
  logic pal_hit;
  logic hit;
  logic wr_en;
  logic [31:0] rd_mux;
  logic dclk_s1_q, dclk_s2_q, dclk_s3_q;
  logic dot_rise;
  fetch_state_t fetch_q;
  logic [11:0] pixels;
  logic [11:0] remain_q;
  logic [5:0] beat_q;
  logic [5:0] burst_len_q;
  logic [10:0] wr_ptr_q;
  logic [10:0] rd_ptr_q;
  logic [10:0] line_cnt_q;
  logic [31:0] line_addr_q;
  logic st1_q, st2_q;
  logic [15:0] direct_q;
  logic [15:0] pixel_q;
  logic power_on;
  logic fetch_ok;
  logic [23:0] entry;

  // ==================================================
  // APB decode
  assign idx = paddr[13:2];
  assign pal_hit = (idx >= `PAL_ENTRY_IDX_BASE) && (idx <= `PAL_ENTRY_IDX_LAST) && (idx[1:0] == 2'h0);
  assign hit = (paddr[1:0] == 2'h0) && (pal_hit || idx == `START_ADDR_IDX || idx == `LINE_OFFSET_IDX ||
    idx == `PAL_CTRL_IDX || idx == `HORIZ_CHARS_IDX || idx == `VERT_LINES_IDX ||
    idx == `POWER_MGMT_IDX || idx == `DISPLAY_CTRL_IDX);

  // Writes finish in the first access cycle; reads take one extra cycle for the palette memory
  assign pready = penable & (pwrite | acc_q);
  assign pslverr = pready & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= psel & penable & ~pwrite & ~acc_q;
    end
  end

  // Read mux; unused high bits and entry bits 31..24 read zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (pal_hit) begin
      rd_mux = {8'h00, pal_port.rdata};
    end else begin
      unique case (idx)
        `START_ADDR_IDX: rd_mux = start_addr_q;
        `LINE_OFFSET_IDX: rd_mux = {16'h0000, line_offset_q};
        `PAL_CTRL_IDX: begin
          rd_mux[`PAL_WRITE_EN_BIT] = palette_write_enable_q;
          rd_mux[`PAL_STATE_BIT] = palette_state_flag_q;
        end
        `HORIZ_CHARS_IDX: rd_mux = {16'h0000, horiz_chars_q};
        `VERT_LINES_IDX: rd_mux = {16'h0000, vert_lines_q};
        `POWER_MGMT_IDX: rd_mux = {16'h0000, power_mgmt_q[15:2], power_state_q};
        `DISPLAY_CTRL_IDX: rd_mux = {16'h0000, display_ctrl_q};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Read data is captured in the first access cycle, when the palette word is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && penable && !pwrite && !acc_q) begin
      prdata_q <= rd_mux;
    end
  end

  // ==================================================
  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_addr_q <= `START_ADDR_RST;
      line_offset_q <= `LINE_OFFSET_RST;
      horiz_chars_q <= `HORIZ_CHARS_RST;
      vert_lines_q <= `VERT_LINES_RST;
      power_mgmt_q <= `POWER_MGMT_RST;
      display_ctrl_q <= `DISPLAY_CTRL_RST;
      palette_write_enable_q <= 1'b0;
    end else if (wr_en) begin
      unique case (idx)
        `START_ADDR_IDX: start_addr_q <= pwdata;
        `LINE_OFFSET_IDX: line_offset_q <= pwdata[15:0];
        `PAL_CTRL_IDX: palette_write_enable_q <= pwdata[`PAL_WRITE_EN_BIT];
        `HORIZ_CHARS_IDX: horiz_chars_q <= pwdata[15:0];
        `VERT_LINES_IDX: vert_lines_q <= pwdata[15:0];
        `POWER_MGMT_IDX: power_mgmt_q <= pwdata[15:0];
        `DISPLAY_CTRL_IDX: display_ctrl_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ==================================================
  // Palette update handshake
  // Entry takes three clocks so an in-flight lookup drains before software may write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pal_cnt_q <= 2'h0;
      palette_state_flag_q <= 1'b0;
    end else if (!palette_write_enable_q) begin
      pal_cnt_q <= 2'h0;
      palette_state_flag_q <= 1'b0;
    end else if (!palette_state_flag_q) begin
      pal_cnt_q <= pal_cnt_q + 2'h1;
      if (pal_cnt_q == `PAL_ENTER_CYC) begin
        palette_state_flag_q <= 1'b1;
      end
    end
  end

  // Table writes land regardless of mode; software holds off until the flag reads 1
  assign pal_port.we = wr_en & pal_hit;
  assign pal_port.waddr = idx[9:2];
  assign pal_port.wdata = pwdata[23:0];
  // A bus read of the table borrows the read port for its duration
  assign pal_port.raddr = (psel && pal_hit && !pwrite) ? idx[9:2] : lb_port.rdata[7:0];

  // ==================================================
  // Display power sequencing: 00 -> 01 -> 11 on, reversed for off
  assign power_on = (power_state_q == 2'b11);
  assign display_on_out = power_on;
  // New bursts also need display-on still asked for, so no request rises as power steps down
  assign fetch_ok = power_on & display_ctrl_q[`DISPLAY_ON_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state_q <= 2'b00;
      pwr_cnt_q <= 16'h0000;
    end else if (display_ctrl_q[`DISPLAY_ON_BIT] ? (power_state_q == 2'b11) : (power_state_q == 2'b00)) begin
      pwr_cnt_q <= 16'h0000;
    end else if (pwr_cnt_q < 16'(PWR_STEP_CYCLES - 1)) begin
      pwr_cnt_q <= pwr_cnt_q + 16'h0001;
    end else begin
      pwr_cnt_q <= 16'h0000;
      if (display_ctrl_q[`DISPLAY_ON_BIT]) begin
        power_state_q <= {power_state_q[0], 1'b1};
      end else begin
        power_state_q <= {1'b0, power_state_q[1]};
      end
    end
  end

  // ==================================================
  // Dot clock sampling; the second and third stages feed the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dclk_s1_q <= 1'b0;
      dclk_s2_q <= 1'b0;
      dclk_s3_q <= 1'b0;
    end else begin
      dclk_s1_q <= panel_dot_clock;
      dclk_s2_q <= dclk_s1_q;
      dclk_s3_q <= dclk_s2_q;
    end
  end

  assign dot_rise = dclk_s2_q & ~dclk_s3_q;

  // ==================================================
  // Line fetch and show
  assign pixels = {1'b0, horiz_chars_q[`HORIZ_DISPLAY_CHARS_MSB:`HORIZ_DISPLAY_CHARS_LSB], 3'h0} + 12'h008;
  assign mem_req = (fetch_q == FETCH_REQ);
  assign mem_addr = line_addr_q;
  assign mem_burst_len = burst_len_q;
  assign lb_port.we = (fetch_q == FETCH_DATA) & mem_rvalid;
  assign lb_port.waddr = wr_ptr_q;
  assign lb_port.wdata = mem_rdata;
  assign lb_port.raddr = rd_ptr_q;

  // Fetch starts only at full power, so turning the display off ends memory traffic once the burst in flight is done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_q <= FETCH_IDLE;
      remain_q <= 12'h000;
      beat_q <= 6'h00;
      burst_len_q <= 6'h00;
      wr_ptr_q <= 11'h000;
      rd_ptr_q <= 11'h000;
      line_cnt_q <= 11'h000;
      line_addr_q <= 32'h00000000;
    end else begin
      unique case (fetch_q)
        FETCH_IDLE: begin
          line_cnt_q <= 11'h000;
          wr_ptr_q <= 11'h000;
          remain_q <= pixels;
          line_addr_q <= start_addr_q;
          burst_len_q <= (pixels > 12'(`MAX_BURST)) ? `MAX_BURST : pixels[5:0];
          if (fetch_ok) begin
            fetch_q <= FETCH_REQ;
          end
        end
        FETCH_REQ: begin
          beat_q <= 6'h00;
          // A raised request is held until granted, so the memory side never sees it withdrawn
          if (mem_gnt) begin
            fetch_q <= FETCH_DATA;
          end
        end
        FETCH_DATA: begin
          if (mem_rvalid) begin
            wr_ptr_q <= wr_ptr_q + 11'h001;
            beat_q <= beat_q + 6'h01;
            if (beat_q == burst_len_q - 6'h01) begin
              remain_q <= remain_q - 12'(burst_len_q);
              line_addr_q <= line_addr_q + 32'({burst_len_q, 1'b0});
              if (remain_q == 12'(burst_len_q)) begin
                rd_ptr_q <= 11'h000;
                fetch_q <= LINE_SHOW;
              end else begin
                burst_len_q <= ((remain_q - 12'(burst_len_q)) > 12'(`MAX_BURST)) ? `MAX_BURST :
                  6'(remain_q - 12'(burst_len_q));
                fetch_q <= fetch_ok ? FETCH_REQ : FETCH_IDLE;
              end
            end
          end
        end
        LINE_SHOW: begin
          if (dot_rise) begin
            rd_ptr_q <= rd_ptr_q + 11'h001;
            if (rd_ptr_q == 11'(pixels - 12'h001)) begin
              wr_ptr_q <= 11'h000;
              remain_q <= pixels;
              burst_len_q <= (pixels > 12'(`MAX_BURST)) ? `MAX_BURST : pixels[5:0];
              if (line_cnt_q == vert_lines_q[`VERT_DISPLAY_LINES_MSB:0]) begin
                line_cnt_q <= 11'h000;
                line_addr_q <= start_addr_q;
              end else begin
                line_cnt_q <= line_cnt_q + 11'h001;
                line_addr_q <= start_addr_q + (32'(line_cnt_q + 11'h001) * 32'(line_offset_q));
              end
              fetch_q <= fetch_ok ? FETCH_REQ : FETCH_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==================================================
  // Pixel pipeline: buffer read, table lookup, output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st1_q <= 1'b0;
      st2_q <= 1'b0;
      direct_q <= 16'h0000;
    end else begin
      st1_q <= (fetch_q == LINE_SHOW) & dot_rise;
      st2_q <= st1_q;
      if (st1_q) begin
        direct_q <= lb_port.rdata;
      end
    end
  end

  // Entry reduced to 5:6:5; mono spreads the grey byte over all three fields
  assign entry = pal_port.rdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_q <= 16'h0000;
    end else if (!power_on) begin
      pixel_q <= 16'h0000;
    end else if (st2_q) begin
      if (!display_ctrl_q[`INDEXED_MODE_BIT]) begin
        pixel_q <= direct_q;
      end else if (display_ctrl_q[`MONO_MODE_BIT]) begin
        pixel_q <= {entry[7:3], entry[7:2], entry[7:3]};
      end else begin
        pixel_q <= {entry[23:19], entry[15:10], entry[7:3]};
      end
    end
  end

  // Forced zero while the table is open for update
  assign panel_pixel_out = palette_state_flag_q ? 16'h0000 : pixel_q;

endmodule : lcd_palette_ctrl
`default_nettype wire

// ===== test/lcd_palette_ctrl_props.sv
// Port-level checks for the palette and display-halt block
`timescale 1ns/1ps
`default_nettype none
module lcd_palette_ctrl_props #(
  parameter int PWR_STEP_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] panel_pixel_out,
  input wire logic display_on_out,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [5:0] mem_burst_len,
  input wire logic mem_gnt
);
  localparam int OFF_MAX = PWR_STEP_CYCLES + 4;
  logic en_q;
  logic [1:0] age_q;
  wire logic wr_acc = psel && penable && pwrite;
  // Shadow of the update request; age saturates once the mode must be entered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      age_q <= 2'h0;
    end else if (wr_acc && paddr == 14'h3048) begin
      en_q <= pwdata[0];
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Register bus
  sequence s_rd_setup;
    psel && !penable && !pwrite ##1 psel && penable;
  endsequence
  sequence s_disp_wr;
    wr_acc && paddr == 14'h30A0;
  endsequence
  a_write_no_wait: assert property (wr_acc |-> pready) else $error("write not answered at once");
  a_read_one_wait: assert property (s_rd_setup |-> !pready ##1 pready) else $error("read wait wrong");
  a_err_unaligned: assert property (wr_acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("bad write taken");
  a_err_in_access: assert property (pslverr |-> pready && penable) else $error("error outside access");
  // ==========================================================
  // Pixels, fetch and display power
  a_update_blank: assert property (en_q && age_q == 2'h3 |-> panel_pixel_out == 16'h0000)
    else $error("pixels not blanked");
  a_req_stable: assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_burst_len))
    else $error("request changed");
  a_burst_max: assert property (mem_req |-> mem_burst_len != 6'h00 && mem_burst_len <= 6'h20)
    else $error("burst length out of range");
  a_fetch_on: assert property ($rose(mem_req) |-> display_on_out) else $error("fetch while off");
  a_on_delayed: assert property ((s_disp_wr and (pwdata[0] && !display_on_out)) |=> !display_on_out [*2])
    else $error("power-up too fast");
  a_off_bounded: assert property ((s_disp_wr and !pwdata[0]) |-> ##[1:OFF_MAX] !display_on_out)
    else $error("display did not go off");
endmodule : lcd_palette_ctrl_props
bind lcd_palette_ctrl lcd_palette_ctrl_props #(.PWR_STEP_CYCLES(PWR_STEP_CYCLES)) lcd_palette_ctrl_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .panel_pixel_out(panel_pixel_out),
  .display_on_out(display_on_out), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_burst_len(mem_burst_len), .mem_gnt(mem_gnt));
`default_nettype wire

// ===== test/frame_mem_model.sv
// Shared frame memory answering burst reads
`timescale 1ns/1ps
`default_nettype none
module frame_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [5:0] mem_burst_len,
  input wire logic [15:0] fill,
  input wire logic slow,
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [15:0] mem_rdata
);
  logic [5:0] left_q;
  logic [2:0] tick_q;
  // One burst at a time; slow mode delays the grant and spaces the beats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      left_q <= 6'h00;
      tick_q <= 3'h0;
      mem_rdata <= 16'hFFFF;
    end else begin
      tick_q <= tick_q + 3'h1;
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata; // Idle data changes so stale words never look valid
      if (left_q == 6'h00) begin
        if (mem_req && !mem_gnt && (!slow || tick_q == 3'h0)) begin
          mem_gnt <= 1'b1;
          left_q <= mem_burst_len;
        end
      end else if (!slow || tick_q[0]) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= fill;
        left_q <= left_q - 6'h01;
      end
    end
  end
endmodule : frame_mem_model
`default_nettype wire

// ===== test/lcd_palette_ctrl_tb.sv
// Self-checking bench for the palette and display-halt block
`timescale 1ns/1ps
`default_nettype none
module lcd_palette_ctrl_tb;
  logic pclk = 1'b0;
  logic dot = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic err, pready, pslverr, don, req, gnt, rv;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, pal5, maddr;
  logic [31:0] seed = 32'h45;
  logic [15:0] pix, rdat;
  logic [15:0] fill = 16'h0005;
  logic [5:0] blen;
  logic [31:0] qa[$];
  logic [5:0] ql[$];
  logic [13:0] ra[7] = '{14'h3020, 14'h3040, 14'h3048, 14'h3050, 14'h3060, 14'h3090, 14'h30A0};
  logic [31:0] rz[7] = '{32'h0C000000, 32'h280, 32'h0, 32'h4F52, 32'h1DF, 32'h10, 32'h0};
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;
  // ==========================================================
  // Clocks; the dot clock is kept off phase from the bus clock
  always #50 pclk = ~pclk;
  initial begin
    #17;
    forever #400 dot = ~dot;
  end
  lcd_palette_ctrl #(.PWR_STEP_CYCLES(2)) lcd_palette_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .panel_dot_clock(dot),
    .panel_pixel_out(pix), .display_on_out(don), .mem_req(req), .mem_addr(maddr),
    .mem_burst_len(blen), .mem_gnt(gnt), .mem_rvalid(rv), .mem_rdata(rdat));
  frame_mem_model frame_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(req),
    .mem_burst_len(blen), .fill(fill), .slow(slow), .mem_gnt(gnt), .mem_rvalid(rv), .mem_rdata(rdat));
  // Log each grant mid-cycle, where the request is steady
  always @(negedge pclk) begin
    if (req === 1'b1 && gnt === 1'b1) begin
      qa.push_back(maddr);
      ql.push_back(blen);
    end
  end
  // Hang guard: the whole run needs a few thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [31:0] to565(input logic [31:0] e);
    return {16'h0, e[23:19], e[15:10], e[7:3]};
  endfunction : to565
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Pready and read data are taken at the rising edge; the request is released just after it
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input logic [13:0] a, input logic [31:0] m, input logic [31:0] x);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, a, 32'h0);
      if ((rd & m) === x) break;
    end
  endtask : poll
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rd, rz[i]);
    end
    apb(1'b0, 14'h0100, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 14'h3049, 32'h1);
    chk("unaligned err", {31'h0, err}, 32'h1);
    $display("test reset and refusals done");
    // Update mode first: the read right after the request still sees the flag low
    apb(1'b1, 14'h3048, 32'h1);
    apb(1'b0, 14'h3048, 32'h0);
    chk("flag early", rd, 32'h1);
    poll(14'h3048, 32'h100, 32'h100);
    chk("flag set", rd, 32'h101);
    // Entries: corners first, then entry 5, then random places; the top byte never sticks
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      k = (i == 0) ? 0 : (i == 1) ? 255 : (i == 2) ? 5 : (seed[31:24] == 8'h05) ? 6 : int'(seed[31:24]);
      v = (k == 5) ? (seed | 32'h808080) : seed;
      if (k == 5) pal5 = v;
      apb(1'b1, {2'b10, k[7:0], 4'h0}, v);
      apb(1'b0, {2'b10, k[7:0], 4'h0}, 32'h0);
      chk("entry", rd, {8'h00, v[23:0]});
    end
    apb(1'b1, 14'h3048, 32'h0);
    apb(1'b0, 14'h3048, 32'h0);
    chk("flag clear", rd, 32'h0);
    $display("test palette done");
    // Two lines of 40 dots, indexed through entry 5
    apb(1'b1, 14'h3040, 32'h200);
    apb(1'b1, 14'h3050, 32'h400);
    apb(1'b1, 14'h3060, 32'h1);
    slow <= seed[0];
    apb(1'b1, 14'h30A0, 32'h101);
    poll(14'h3090, 32'h3, 32'h3);
    chk("power up", rd & 32'h3, 32'h3);
    chk("display on", {31'h0, don}, 32'h1);
    while (ql.size() < 4) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      chk("burst len", {26'h0, ql[i]}, i[0] ? 32'h8 : 32'h20);
    end
    chk("line 0 addr", qa[0], 32'h0C000000);
    chk("line 1 addr", qa[2], 32'h0C000200);
    k = 0;
    while (pix === 16'h0 && k < 3000) begin
      @(negedge pclk);
      k++;
    end
    chk("pixel", {16'h0, pix}, to565(pal5));
    // Mono spreads the grey byte; direct mode passes the fetched word untouched
    apb(1'b1, 14'h30A0, 32'h301);
    repeat (200) @(negedge pclk);
    chk("mono pixel", {16'h0, pix}, {16'h0, pal5[7:3], pal5[7:2], pal5[7:3]});
    apb(1'b1, 14'h30A0, 32'h1);
    repeat (200) @(negedge pclk);
    chk("direct pixel", {16'h0, pix}, {16'h0, fill});
    apb(1'b1, 14'h3048, 32'h1);
    poll(14'h3048, 32'h100, 32'h100);
    chk("blanked", {16'h0, pix}, 32'h0);
    apb(1'b1, 14'h3048, 32'h0);
    $display("test display done");
    apb(1'b1, 14'h30A0, 32'h100);
    poll(14'h3090, 32'h3, 32'h0);
    chk("power down", rd & 32'h3, 32'h0);
    chk("display off", {31'h0, don}, 32'h0);
    k = ql.size();
    repeat (700) @(posedge pclk);
    chk("fetch stopped", ql.size(), k);
    $display("test halt done");
    give_verdict();
  end
endmodule : lcd_palette_ctrl_tb
`default_nettype wire
